// File: srav_pkg.sv
// Package for the attribute-values record command block: register map, codes, record layout, resets.
// Assumes a 32-bit AXI4-Lite master with byte addresses and one clock domain.
package srav_pkg;
	// Register byte addresses
	localparam logic [7:0] A_DATA  = 8'h00;
	localparam logic [7:0] A_FEAT  = 8'h04;
	localparam logic [7:0] A_CYLLO = 8'h10;
	localparam logic [7:0] A_CYLHI = 8'h14;
	localparam logic [7:0] A_CMD   = 8'h1c;
	localparam logic [7:0] A_CFG   = 8'h20;
	localparam logic [7:0] A_COUNT = 8'h24;
	localparam logic [7:0] A_SEL   = 8'h28;
	localparam logic [7:0] A_ATTR  = 8'h2c;
	// Command codes and key values
	localparam logic [7:0] CMD_SMART  = 8'hb0;
	localparam logic [7:0] FEAT_RDVAL = 8'hd0;
	localparam logic [7:0] KEY_LO     = 8'h4f;
	localparam logic [7:0] KEY_HI     = 8'hc2;
	// Status and error bit positions
	localparam int ST_BSY_BIT  = 7;
	localparam int ST_DRDY_BIT = 6;
	localparam int ST_DRQ_BIT  = 3;
	localparam int ST_ERR_BIT  = 0;
	localparam int ER_ABRT_BIT = 2;
	// Record layout, byte offsets
	localparam logic [15:0] REV_WORD   = 16'h0004;
	localparam logic [8:0]  SLOT_BASE  = 9'd2;
	localparam logic [8:0]  SLOT_BYTES = 9'd12;
	localparam logic [4:0]  SLOT_NUM   = 5'd30;
	localparam logic [8:0]  RSV_BASE   = 9'd362;
	localparam logic [8:0]  CAP_BASE   = 9'd368;
	localparam logic [7:0]  LAST_WORD  = 8'hff;
	localparam logic [3:0]  POS_ID     = 4'd0;
	localparam logic [3:0]  POS_FLO    = 4'd1;
	localparam logic [3:0]  POS_VAL    = 4'd3;
	// Attribute value codes
	localparam logic [7:0] VAL_INIT  = 8'h64;
	localparam logic [7:0] VAL_BAD   = 8'hfe;
	localparam logic [7:0] VAL_ZERO  = 8'h00;
	localparam logic [7:0] VAL_ONES  = 8'hff;
	// Reset values
	localparam logic [4:0] CFG_RST   = 5'h01;
	localparam logic [4:0] COUNT_RST = 5'h00;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Command sequencer, Gray coded
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_XFER = 2'b11
	} srav_state_t;
endpackage

// File: srav_cmd.sv
// Device-side interpreter for the read-attribute-values command, with record assembly.
// Assumes the task file is reached over AXI4-Lite and the nonvolatile store answers on the same clock.
//
// Notes on behaviour
// - Abort on no support, SMART off or bad qualifiers; set error and abort bits.
// - Accept: busy, commit attributes, then DRQ, busy off, INTRQ; await 512-byte read.
// - Entries keep their table slot after the revision word; an empty slot below the count stays in place as zeros.
// - Active count chosen per device up to thirty; unused slots read zero.
// - Layout: revision, thirty slots, reserved, capability, reserved, vendor, checksum.
// - First two bytes carry the structure revision, same as threshold record.
// - Slot is id, flag word, value, eight vendor bytes.
// - Nonzero id marks an active slot, zero marks empty.
// - Value stays in range; all-zeros and all-ones are never reported.
// - Before monitoring starts every value reads as the initial value.
// - Flag bit zero marks pre-failure versus advisory.
// - Flag bit one and bits seven up are reserved; three to six vendor.
// - Final byte makes all 512 bytes sum to zero.
// - Capability bit zero pre-power save, bit one autosave supported, rest reserved.
`timescale 1ns/100ps
module srav_cmd (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic             o_nv_save_req,
	input  wire logic        i_nv_save_done,
	output logic             o_intrq
);
	import srav_pkg::*;

	typedef struct packed {
		srav_state_t         st;
		logic [7:0]          feat;
		logic [7:0]          cyl_lo;
		logic [7:0]          cyl_hi;
		logic                bsy;
		logic                drq;
		logic                err;
		logic                abrt;
		logic                intrq;
		logic                nv_req;
		logic [4:0]          cfg;
		logic [4:0]          count;
		logic [4:0]          sel;
		logic [29:0][7:0]    id;
		logic [29:0][7:0]    val;
		logic [29:0][4:0]    flg;
		logic [7:0]          widx;
		logic [7:0]          sum;
		logic                aw_got;
		logic [7:0]          awaddr;
		logic                w_got;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} srav_st_t;

	srav_st_t s;
	srav_st_t next_s;
	logic     cmd_ok;
	logic     cmd_fire;
	logic     data_fire;
	logic     idle;

	// Flag word from stored bits; bit 1, bit 2 and bits 7..15 forced to zero
	function automatic logic [15:0] flag_word(input logic [4:0] f);
		return {9'h000, f[4:1], 2'b00, f[0]};
	endfunction

	// Reported value: initial code before monitoring, reserved codes mapped to not-valid
	function automatic logic [7:0] rep_val(input logic mon, input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (!mon)
			r = VAL_INIT;
		else if (v == VAL_ZERO || v == VAL_ONES)
			r = VAL_BAD;
		return r;
	endfunction

	// One record byte by offset; computed on the fly so no 512-byte buffer is kept
	function automatic logic [7:0] rec_byte(input srav_st_t t, input logic [8:0] off);
		logic [8:0]  rel;
		logic [4:0]  slot;
		logic [3:0]  pos;
		logic [15:0] fw;
		logic [7:0]  b;
		rel  = off - SLOT_BASE;
		slot = 5'(rel / SLOT_BYTES);
		pos  = 4'(rel % SLOT_BYTES);
		fw   = 16'h0000;
		b    = 8'h00;
		if (off == 9'd0)
			b = REV_WORD[7:0];
		else if (off == 9'd1)
			b = REV_WORD[15:8];
		else if (off < RSV_BASE) begin
			if (slot < t.count && t.id[slot] != 8'h00) begin
				fw = flag_word(t.flg[slot]);
				unique case (pos)
					POS_ID:  b = t.id[slot];
					POS_FLO: b = fw[7:0];
					4'd2:    b = fw[15:8];
					POS_VAL: b = rep_val(t.cfg[2], t.val[slot]);
					default: b = 8'h00; // Vendor bytes left zero
				endcase
			end
		end else if (off == CAP_BASE)
			b = {6'h00, t.cfg[4:3]};
		return b;
	endfunction

	// Handshake readies straight from state
	assign o_awready     = !s.aw_got && !s.bvalid;
	assign o_wready      = !s.w_got && !s.bvalid;
	assign o_arready     = !s.rvalid;
	assign o_bvalid      = s.bvalid;
	assign o_bresp       = s.bresp;
	assign o_rvalid      = s.rvalid;
	assign o_rdata       = s.rdata;
	assign o_rresp       = s.rresp;
	assign o_nv_save_req = s.nv_req;
	assign o_intrq       = s.intrq;
	assign idle          = s.st == ST_IDLE;

	// Qualifier check on the latched command byte
	assign cmd_ok = s.cfg[0] && s.cfg[1] && s.wdata[7:0] == CMD_SMART && s.feat == FEAT_RDVAL
		&& s.cyl_lo == KEY_LO && s.cyl_hi == KEY_HI;

	// Next state; read side first so that later events setting INTRQ win over a status-read clear
	always_comb begin
		logic [7:0] lo;
		logic [7:0] hi;
		lo        = 8'h00;
		hi        = 8'h00;
		next_s    = s;
		cmd_fire  = 1'b0;
		data_fire = 1'b0;
		if (i_rready && s.rvalid)
			next_s.rvalid = 1'b0;
		if (i_arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			next_s.rdata  = 32'h0000_0000;
			case (i_araddr)
				A_DATA: begin
					if (s.st == ST_XFER) begin
						data_fire = 1'b1;
						lo = rec_byte(s, {s.widx, 1'b0});
						if (s.widx == LAST_WORD)
							hi = 8'h00 - 8'(s.sum + lo);
						else
							hi = rec_byte(s, {s.widx, 1'b1});
						next_s.rdata = {16'h0000, hi, lo};
						next_s.sum   = 8'(s.sum + lo + hi);
						next_s.widx  = 8'(s.widx + 8'h01);
						if (s.widx == LAST_WORD) begin
							next_s.st  = ST_IDLE;
							next_s.drq = 1'b0;
						end
					end
				end
				A_FEAT: next_s.rdata[ER_ABRT_BIT] = s.abrt;
				A_CYLLO: next_s.rdata[7:0] = s.cyl_lo;
				A_CYLHI: next_s.rdata[7:0] = s.cyl_hi;
				A_CMD: begin
					next_s.rdata[ST_BSY_BIT]  = s.bsy;
					next_s.rdata[ST_DRDY_BIT] = 1'b1; // Always ready; no spin-up modelled
					next_s.rdata[ST_DRQ_BIT]  = s.drq;
					next_s.rdata[ST_ERR_BIT]  = s.err;
					next_s.intrq              = 1'b0; // Status read acknowledges the interrupt
				end
				A_CFG: next_s.rdata[4:0] = s.cfg;
				A_COUNT: next_s.rdata[4:0] = s.count;
				A_SEL: next_s.rdata[4:0] = s.sel;
				A_ATTR: begin
					if (s.sel < SLOT_NUM)
						next_s.rdata = {flag_word(s.flg[s.sel]), s.val[s.sel], s.id[s.sel]};
				end
				default: next_s.rresp = RESP_SLVERR;
			endcase
		end
		// Write address and data are taken in either order and applied once both are held
		if (i_awvalid && o_awready) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = i_wdata;
			next_s.wstrb = i_wstrb;
		end
		if (i_bready && s.bvalid)
			next_s.bvalid = 1'b0;
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = RESP_OKAY;
			// Task file and tables are frozen while a command runs, keeping the record stable
			case (s.awaddr)
				A_FEAT: if (idle && s.wstrb[0]) next_s.feat = s.wdata[7:0];
				A_CYLLO: if (idle && s.wstrb[0]) next_s.cyl_lo = s.wdata[7:0];
				A_CYLHI: if (idle && s.wstrb[0]) next_s.cyl_hi = s.wdata[7:0];
				A_CMD: begin
					if (idle && s.wstrb[0]) begin
						cmd_fire     = 1'b1;
						next_s.err   = 1'b0;
						next_s.abrt  = 1'b0;
						next_s.intrq = 1'b0;
						if (cmd_ok) begin
							next_s.st     = ST_BUSY;
							next_s.bsy    = 1'b1;
							next_s.nv_req = 1'b1;
						end else begin
							next_s.err   = 1'b1;
							next_s.abrt  = 1'b1;
							next_s.intrq = 1'b1;
						end
					end
				end
				A_CFG: if (idle && s.wstrb[0]) next_s.cfg = s.wdata[4:0];
				A_COUNT: begin
					if (idle && s.wstrb[0])
						next_s.count = (s.wdata[4:0] > SLOT_NUM) ? SLOT_NUM : s.wdata[4:0];
				end
				A_SEL: if (idle && s.wstrb[0]) next_s.sel = s.wdata[4:0];
				A_ATTR: begin
					if (idle && s.sel < SLOT_NUM) begin
						if (s.wstrb[0])
							next_s.id[s.sel] = s.wdata[7:0];
						if (s.wstrb[1])
							next_s.val[s.sel] = s.wdata[15:8];
						if (s.wstrb[2])
							next_s.flg[s.sel] = {s.wdata[22:19], s.wdata[16]};
					end
				end
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		// Sequencer: commit, then hand the record out
		unique case (s.st)
			ST_IDLE: ;
			ST_BUSY: begin
				if (i_nv_save_done) begin
					next_s.st     = ST_XFER;
					next_s.nv_req = 1'b0;
					next_s.bsy    = 1'b0;
					next_s.drq    = 1'b1;
					next_s.intrq  = 1'b1;
					next_s.widx   = 8'h00;
					next_s.sum    = 8'h00;
				end
			end
			ST_XFER: ;
			default: next_s.st = ST_IDLE;
		endcase
	end

	// Register the whole state; synchronous reset
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s       <= '0;
			s.st    <= ST_IDLE;
			s.cfg   <= CFG_RST;
			s.count <= COUNT_RST;
		end else begin
			s <= next_s;
		end
	end

	abort_flags_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		cmd_fire && !cmd_ok |=> s.err && s.abrt && s.intrq && idle)
		else $error("bad command not aborted");
	commit_first_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$rose(s.drq) |-> $past(s.st) == ST_BUSY && $past(i_nv_save_done) && !s.bsy && s.intrq)
		else $error("data offered without commit");
	accept_busy_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		cmd_fire && cmd_ok |=> s.bsy && !s.drq && s.nv_req)
		else $error("accepted command not busy");
	bsy_drq_excl_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!(s.bsy && s.drq))
		else $error("busy and data request together");
	rev_word_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		data_fire && s.widx == 8'h00 |=> s.rdata[15:0] == REV_WORD)
		else $error("revision word wrong");
	checksum_zero_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		data_fire && s.widx == LAST_WORD |=> s.sum == 8'h00)
		else $error("record sum not zero");
	idle_after_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		data_fire && s.widx == LAST_WORD |=> idle && !s.drq ##1 !s.drq)
		else $error("no idle after record");
	value_code_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s.count != 5'h00 && s.id[0] != 8'h00 |->
		rec_byte(s, 9'd5) != VAL_ZERO && rec_byte(s, 9'd5) != VAL_ONES)
		else $error("reserved value code reported");
	init_value_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!s.cfg[2] && s.count != 5'h00 && s.id[0] != 8'h00 |-> rec_byte(s, 9'd5) == VAL_INIT)
		else $error("initial value not shown");
	empty_slot_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s.count == 5'h00 |-> rec_byte(s, 9'd2) == 8'h00 && rec_byte(s, 9'd5) == 8'h00)
		else $error("unused slot not zero");
	cap_rsvd_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rec_byte(s, CAP_BASE + 9'd1) == 8'h00 && (rec_byte(s, CAP_BASE) & 8'hfc) == 8'h00)
		else $error("capability reserved bits set");
endmodule // srav_cmd

// File: srav_nv_model.sv
// Store model for the attribute commit handshake, prompt or slow by i_delay.
// Assumes the commit request is a level held until done, on the block's clock.
`timescale 1ns/100ps
module srav_nv_model (
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	input  wire logic [7:0] i_delay,
	input  wire logic       i_save_req,
	output logic            o_save_done
);
	logic [7:0] cnt;

	// Counts while asked; done is a single pulse, the least a real store gives
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || !i_save_req || o_save_done) begin
			cnt         <= 8'h00;
			o_save_done <= 1'b0;
		end else begin
			cnt         <= cnt + 8'h01;
			o_save_done <= (cnt >= i_delay);
		end
	end
endmodule // srav_nv_model

// File: srav_cmd_tb.sv
// Self-checking bench for the attribute-values command block, driven over AXI4-Lite.
// Assumes one 10 MHz clock and the store model answering commit requests.
`timescale 1ns/100ps
module srav_cmd_tb;
	import srav_pkg::*;
	logic        clk, awr, wr_r, bv, arr, rv, req, done, irq;
	logic        rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [7:0]  awa = 8'h00, ara = 8'h00, dly = 8'h00;
	logic [3:0]  ws = 4'hf;
	logic [31:0] wd = 32'h0, rd_d, rdat;
	logic [1:0]  br, rr, resp;
	logic [7:0]  eb [512];
	logic [7:0]  sid [4] = '{8'h05, 8'h0a, 8'h00, 8'h07};
	logic [7:0]  sv [4]  = '{8'h80, 8'h00, 8'h33, 8'hff};
	logic [39:0] bad [6] = '{40'h01d04fc2b0, 40'h02d04fc2b0, 40'h03d14fc2b0,
		40'h03d04ec2b0, 40'h03d04fc3b0, 40'h03d04fc2b1};
	int          n_mismatch = 0;
	int          cmp_count  = 0;

	srav_cmd u_dut (
		.i_clock(clk), .i_rst_n(rst_n), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
		.i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr_r), .o_bresp(br), .o_bvalid(bv),
		.i_bready(bry), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd_d),
		.o_rresp(rr), .o_rvalid(rv), .i_rready(rry), .o_nv_save_req(req),
		.i_nv_save_done(done), .o_intrq(irq)
	);
	srav_nv_model u_nv (
		.i_clock(clk), .i_rst_n(rst_n), .i_delay(dly), .i_save_req(req), .o_save_done(done)
	);

	// Clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Readies sampled mid-cycle, where they are settled, then acted on at the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa = 1'b1, pw = 1'b1, kb = 1'b0, ka, kw;
		@(posedge clk);
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bry <= 1'b1;
		for (int t = 0; t < 40 && !kb; t++) begin
			@(negedge clk);
			ka   = pa && awr;
			kw   = pw && wr_r;
			kb   = bv;
			resp = br;
			@(posedge clk);
			if (ka) awv <= 1'b0;
			if (kw) wv <= 1'b0;
			pa = pa && !ka;
			pw = pw && !kw;
		end
		bry <= 1'b0;
		check({31'h0, kb}, 32'h1); // Lost write response counts as a mismatch
	endtask

	task automatic rd(input logic [7:0] a);
		logic pr = 1'b1, kr = 1'b0, ka;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (int t = 0; t < 40 && !kr; t++) begin
			@(negedge clk);
			ka   = pr && arr;
			kr   = rv;
			rdat = rd_d;
			resp = rr;
			@(posedge clk);
			if (ka) arv <= 1'b0;
			pr = pr && !ka;
		end
		rry <= 1'b0;
		check({31'h0, kr}, 32'h1); // Lost read response counts as a mismatch
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		check(rdat, e);
	endtask

	// Packed as config, features, cylinder low, cylinder high, command
	task automatic cmd(input logic [39:0] p);
		wr(A_CFG, {24'h0, p[39:32]});
		wr(A_FEAT, {24'h0, p[31:24]});
		wr(A_CYLLO, {24'h0, p[23:16]});
		wr(A_CYLHI, {24'h0, p[15:8]});
		wr(A_CMD, {24'h0, p[7:0]});
	endtask

	// Expected record from the slot table; only the first three slots are counted active
	task automatic build(input logic mon, input logic [7:0] cap);
		logic [7:0] s = 8'h00;
		int         k;
		for (int i = 0; i < 512; i++) eb[i] = 8'h00;
		eb[0] = 8'h04;
		for (int i = 0; i < 3; i++) begin
			k = 2 + 12 * i;
			if (sid[i] != 8'h00) begin
				eb[k]   = sid[i];
				eb[k+1] = 8'h79;
				eb[k+3] = !mon ? 8'h64 : (sv[i] == 8'h00 || sv[i] == 8'hff) ? 8'hfe : sv[i];
			end
		end
		eb[368] = cap;
		for (int i = 0; i < 511; i++) s += eb[i];
		eb[511] = 8'h00 - s;
	endtask

	// Accepted command, record read whole, then back to idle
	task automatic good(input logic [7:0] c, input logic [7:0] d, input logic [7:0] cap);
		dly <= d;
		build(c[2], cap);
		cmd({c, 8'hd0, 8'h4f, 8'hc2, 8'hb0});
		if (d > 8'h08) begin
			rc(A_CMD, 32'hc0);
			@(negedge clk);
			check({31'h0, req}, 32'h1);
		end
		for (int t = 0; t < 200 && irq !== 1'b1; t++) @(negedge clk);
		check({31'h0, irq}, 32'h1);
		rc(A_CMD, 32'h48);
		@(negedge clk);
		check({31'h0, irq}, 32'h0);
		for (int w = 0; w < 256; w++) rc(A_DATA, {16'h0, eb[2*w+1], eb[2*w]});
		rc(A_CMD, 32'h40);
		rc(A_DATA, 32'h0);
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rc(A_CMD, 32'h40);
		rc(A_CFG, 32'h01);
		check({30'h0, resp}, 32'h0);
		rc(8'h08, 32'h0);
		check({30'h0, resp}, {30'h0, 2'b10});
		wr(8'h08, 32'h05);
		check({30'h0, resp}, 32'h2);
		wr(A_COUNT, 32'h1f);
		rc(A_COUNT, 32'h1e);
		wr(A_COUNT, 32'h03);
		check({30'h0, resp}, 32'h0);
		// Low byte lane off: the write is answered but leaves the count alone
		ws <= 4'he;
		wr(A_COUNT, 32'h05);
		ws <= 4'hf;
		rc(A_COUNT, 32'h03);
		for (int i = 0; i < 4; i++) begin
			wr(A_SEL, 32'(i));
			wr(A_ATTR, {16'hffff, sv[i], sid[i]});
		end
		rc(A_ATTR, {16'h0079, 8'hff, 8'h07});
		for (int i = 0; i < 6; i++) begin
			cmd(bad[i]);
			@(negedge clk);
			check({31'h0, irq}, 32'h1);
			rc(A_FEAT, 32'h04);
			rc(A_CMD, 32'h41);
		end
		good(8'h1f, 8'h14, 8'h03);
		good(8'h03, 8'h00, 8'h00);
		summarize();
	end

	// Watchdog, far beyond the few thousand cycles the sequence needs
	initial begin
		#(100 * 20000);
		n_mismatch++;
		summarize();
	end
endmodule // srav_cmd_tb
